// [design/sai_pkg.sv]
// Shared constants and types for the serial audio link ends
package sai_pkg;
    // ------------------------------------------------------------------
    // Clock and start-up timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_FREQ_HZ = 200_000_000;
    localparam int RST_PULSE_US = 100;
    localparam int RST_PULSE_CYC = (RST_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CTRL_READY_US = 13_500;
    localparam int CTRL_READY_CYC = (CTRL_READY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PDN_HOLD_CYC = 16;
    localparam int SEQ_CNT_W = 22;
    localparam int BCLK_HALF_CYC = 16;

    // ------------------------------------------------------------------
    // Framing
    // ------------------------------------------------------------------
    localparam int SAMPLE_W = 16;
    localparam int BIT_CNT_W = 7;
    localparam int CYC_CNT_W = 16;
    localparam int DRIFT_MCLK = 4;
    localparam int LOCK_FRAMES = 2;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_W = 2 * SAMPLE_W;
    localparam int CARRIER_TOL_PCT = 2;
    localparam int RATE_11K = 11025;
    localparam int RATE_22K = 22050;
    localparam int RATE_44K = 44100;

    typedef enum logic [1:0] {
        SAI_RATIO32 = 2'h0,
        SAI_RATIO48 = 2'h1,
        SAI_RATIO64 = 2'h2
    } sai_ratio_e;

    function automatic logic [BIT_CNT_W-1:0] ratioBits(input sai_ratio_e r);
        unique case (r)
            SAI_RATIO48: ratioBits = 7'h30;
            SAI_RATIO64: ratioBits = 7'h40;
            default: ratioBits = 7'h20;
        endcase
    endfunction : ratioBits

    // True when a frame period in clock cycles is within tolerance of a rate
    function automatic logic nearRate(input logic [CYC_CNT_W-1:0] len, input int rate);
        int nom;
        nom = CLK_FREQ_HZ / rate;
        nearRate = (int'(len) * 100 >= nom * (100 - CARRIER_TOL_PCT))
            && (int'(len) * 100 <= nom * (100 + CARRIER_TOL_PCT));
    endfunction : nearRate
endpackage : sai_pkg

// [design/sai_link_if.sv]
// Serial audio link between the source host and the amplifier input
`timescale 1ns/1ps
`default_nettype none
interface sai_link_if;
    logic bitClock;
    logic frameClock;
    logic serialData;
    logic resetN;
    logic powerDownN;

    modport host (
        output bitClock,
        output frameClock,
        output serialData,
        output resetN,
        output powerDownN
    );
    modport device (
        input bitClock,
        input frameClock,
        input serialData,
        input resetN,
        input powerDownN
    );
endinterface : sai_link_if
`default_nettype wire

// [design/sai_device.sv]
// Amplifier serial audio input end: framing tracker, carrier select, sample FIFO
//
// Summary of operation
// - Host holds reset low at least 100 us
// - 32 to 64 bit edges per frame
// - Resync when frame drifts over 4 clocks
// - Data and frame sampled on bit-clock rise
// - Source moves frame near bit-clock fall
// - Reset stays low 100 us after power-down
// - Device only receives clocks, never drives
// - Carrier 384 or 288 kHz by rate
// - Two channels on one data line
// - 44.1 family gives 288, others 384
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Sample FIFO with a registered output stage
// ----------------------------------------------------------------------
module sai_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] count_q, count_d;
    logic outValid_q, outValid_d;
    logic [WIDTH-1:0] outData_q, outData_d;
    logic push, pop;

    always_comb begin
        inReady = (count_q != (AW+1)'(DEPTH));
        push = inValid && inReady;
        pop = (count_q != '0) && (!outValid_q || outReady);
        wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
        rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
        outValid_d = pop ? 1'b1 : (outReady ? 1'b0 : outValid_q);
        outData_d = pop ? mem[rdPtr_q] : outData_q;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            outValid_q <= 1'b0;
            outData_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
            outValid_q <= outValid_d;
            outData_q <= outData_d;
        end
    end

    always_ff @(posedge clock) begin
        if (push) begin
            mem[wrPtr_q] <= inData;
        end
    end

    assign outValid = outValid_q;
    assign outData = outData_q;
endmodule : sai_fifo

// ----------------------------------------------------------------------
// Device end
// ----------------------------------------------------------------------
module sai_device
    import sai_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    sai_link_if.device link,
    output logic audioValid,
    output logic [SAMPLE_W-1:0] audioLeft,
    output logic [SAMPLE_W-1:0] audioRight,
    input wire logic audioReady,
    output logic mute,
    output logic carrier288,
    output logic overrun
);
    typedef enum logic [2:0] {
        ST_HUNT = 3'h1,
        ST_LOCK = 3'h2,
        ST_RUN = 3'h4
    } sai_trk_e;

    // ------------------------------------------------------------------
    // Pin synchronisers; every link pin is an input only
    // ------------------------------------------------------------------
    logic [4:0] syncM_q, syncS_q;
    logic bclkP_q;
    logic bclkS, frmS, datS, rstS, pdnS;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            syncM_q <= '0;
            syncS_q <= '0;
            bclkP_q <= 1'b0;
        end else begin
            syncM_q <= {link.powerDownN, link.resetN, link.serialData,
                link.frameClock, link.bitClock};
            syncS_q <= syncM_q;
            bclkP_q <= syncS_q[0];
        end
    end

    assign {pdnS, rstS, datS, frmS, bclkS} = syncS_q;

    // ------------------------------------------------------------------
    // Frame tracker
    // ------------------------------------------------------------------
    sai_trk_e state_q, state_d;
    logic frmPrev_q, frmPrev_d;
    logic [BIT_CNT_W-1:0] bitCnt_q, bitCnt_d, slotPos_q, slotPos_d;
    logic [CYC_CNT_W-1:0] cycCnt_q, cycCnt_d, frameLen_q, frameLen_d;
    logic [1:0] good_q, good_d;
    logic [SAMPLE_W-1:0] shift_q, shift_d, left_q, left_d;
    logic carrier_q, carrier_d, overrun_q, overrun_d;
    logic bclkRise, frameRise, frameFall, ratioOk, drift, late;
    logic pushValid, pushReady;
    logic [FIFO_W-1:0] pushData;

    always_comb begin
        state_d = state_q;
        frmPrev_d = frmPrev_q;
        bitCnt_d = bitCnt_q;
        slotPos_d = slotPos_q;
        shift_d = shift_q;
        left_d = left_q;
        good_d = good_q;
        frameLen_d = frameLen_q;
        carrier_d = carrier_q;
        pushValid = 1'b0;
        pushData = {left_q, shift_q};
        bclkRise = bclkS && !bclkP_q;
        frameRise = bclkRise && frmS && !frmPrev_q;
        frameFall = bclkRise && !frmS && frmPrev_q;
        ratioOk = (bitCnt_q == ratioBits(SAI_RATIO32)) || (bitCnt_q == ratioBits(SAI_RATIO48))
            || (bitCnt_q == ratioBits(SAI_RATIO64));
        drift = (cycCnt_q > frameLen_q + CYC_CNT_W'(DRIFT_MCLK))
            || (cycCnt_q + CYC_CNT_W'(DRIFT_MCLK) < frameLen_q);
        late = (state_q == ST_RUN) && (cycCnt_q > frameLen_q + CYC_CNT_W'(DRIFT_MCLK));
        cycCnt_d = (cycCnt_q == '1) ? cycCnt_q : cycCnt_q + 1'b1;
        overrun_d = overrun_q;

        if (bclkRise) begin
            frmPrev_d = frmS;
            bitCnt_d = (bitCnt_q == '1) ? bitCnt_q : bitCnt_q + 1'b1;
            if (frameRise || frameFall) begin
                shift_d = {{(SAMPLE_W-1){1'b0}}, datS};
                slotPos_d = 7'h01;
            end else if (slotPos_q < BIT_CNT_W'(SAMPLE_W)) begin
                shift_d = {shift_q[SAMPLE_W-2:0], datS};
                slotPos_d = slotPos_q + 1'b1;
            end
        end
        if (frameRise) begin
            left_d = shift_q;
            bitCnt_d = 7'h01;
            cycCnt_d = '0;
            frameLen_d = cycCnt_q;
            carrier_d = nearRate(cycCnt_q, RATE_11K) || nearRate(cycCnt_q, RATE_22K)
                || nearRate(cycCnt_q, RATE_44K);
        end
        // Right slot closes on the frame fall, completing the stereo pair
        if (frameFall && state_q == ST_RUN) begin
            pushValid = 1'b1;
            // The link cannot be stalled, so a full FIFO drops the pair
            if (!pushReady) begin
                overrun_d = 1'b1;
            end
        end

        unique case (state_q)
            ST_HUNT: begin
                good_d = '0;
                if (frameRise) begin
                    state_d = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (frameRise) begin
                    if (!ratioOk) begin
                        good_d = '0;
                    end else if (good_q == 2'(LOCK_FRAMES - 1)) begin
                        state_d = ST_RUN;
                    end else begin
                        good_d = good_q + 1'b1;
                    end
                end
            end
            ST_RUN: begin
                if (late) begin
                    state_d = ST_HUNT;
                end else if (frameRise && (drift || !ratioOk)) begin
                    state_d = ST_LOCK;
                    good_d = '0;
                end
            end
            default: state_d = ST_HUNT;
        endcase

        // Held in reset or power-down: return to hunt, clear the lock count and stay muted
        if (!rstS || !pdnS) begin
            state_d = ST_HUNT;
            good_d = '0;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_HUNT;
            frmPrev_q <= 1'b0;
            bitCnt_q <= '0;
            slotPos_q <= '0;
            cycCnt_q <= '0;
            frameLen_q <= '0;
            good_q <= '0;
            shift_q <= '0;
            left_q <= '0;
            carrier_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            state_q <= state_d;
            frmPrev_q <= frmPrev_d;
            bitCnt_q <= bitCnt_d;
            slotPos_q <= slotPos_d;
            cycCnt_q <= cycCnt_d;
            frameLen_q <= frameLen_d;
            good_q <= good_d;
            shift_q <= shift_d;
            left_q <= left_d;
            carrier_q <= carrier_d;
            overrun_q <= overrun_d;
        end
    end

    // ------------------------------------------------------------------
    // Output buffering
    // ------------------------------------------------------------------
    logic muteOut_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            muteOut_q <= 1'b1;
        end else begin
            muteOut_q <= (state_d != ST_RUN);
        end
    end

    sai_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .nrst(nrst),
        .inValid(pushValid),
        .inData(pushData),
        .inReady(pushReady),
        .outValid(audioValid),
        .outData({audioLeft, audioRight}),
        .outReady(audioReady)
    );

    assign mute = muteOut_q;
    assign carrier288 = carrier_q;
    assign overrun = overrun_q;
endmodule : sai_device
`default_nettype wire

// [design/sai_host.sv]
// Source host end: start-up sequencing and serial audio transmitter
`timescale 1ns/1ps
`default_nettype none
module sai_host
    import sai_pkg::*;
#(
    parameter int unsigned RST_CYC = RST_PULSE_CYC,
    parameter int unsigned READY_CYC = CTRL_READY_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    sai_link_if.host link,
    input wire logic sampleValid,
    input wire logic [SAMPLE_W-1:0] sampleLeft,
    input wire logic [SAMPLE_W-1:0] sampleRight,
    output logic sampleReady,
    input wire logic [1:0] ratioSel,
    output logic controlReady
);
    typedef enum logic [3:0] {
        SQ_PDN = 4'h1,
        SQ_RST = 4'h2,
        SQ_WAIT = 4'h4,
        SQ_UP = 4'h8
    } sai_seq_e;

    // ------------------------------------------------------------------
    // Start-up sequencer
    // ------------------------------------------------------------------
    sai_seq_e seq_q, seq_d;
    logic [SEQ_CNT_W-1:0] seqCnt_q, seqCnt_d;
    logic audioOn;
    logic linkRst_q, linkRst_d, linkPdn_q, linkPdn_d, ctrlRdy_q, ctrlRdy_d;

    always_comb begin
        seq_d = seq_q;
        seqCnt_d = seqCnt_q + 1'b1;
        unique case (seq_q)
            SQ_PDN: begin
                if (seqCnt_q == SEQ_CNT_W'(PDN_HOLD_CYC - 1)) begin
                    seq_d = SQ_RST;
                    seqCnt_d = '0;
                end
            end
            SQ_RST: begin
                // Reset low is timed from the power-down release
                if (seqCnt_q == SEQ_CNT_W'(RST_CYC - 1)) begin
                    seq_d = SQ_WAIT;
                    seqCnt_d = '0;
                end
            end
            SQ_WAIT: begin
                if (seqCnt_q == SEQ_CNT_W'(READY_CYC - 1)) begin
                    seq_d = SQ_UP;
                    seqCnt_d = '0;
                end
            end
            SQ_UP: seqCnt_d = '0;
            default: seq_d = SQ_PDN;
        endcase
        audioOn = (seq_q == SQ_WAIT) || (seq_q == SQ_UP);
        // Pin levels follow the next state so the registered copy lines up with audioOn
        linkRst_d = (seq_d == SQ_WAIT) || (seq_d == SQ_UP);
        linkPdn_d = (seq_d != SQ_PDN);
        ctrlRdy_d = (seq_d == SQ_UP);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            seq_q <= SQ_PDN;
            seqCnt_q <= '0;
            linkRst_q <= 1'b0;
            linkPdn_q <= 1'b0;
            ctrlRdy_q <= 1'b0;
        end else begin
            seq_q <= seq_d;
            seqCnt_q <= seqCnt_d;
            linkRst_q <= linkRst_d;
            linkPdn_q <= linkPdn_d;
            ctrlRdy_q <= ctrlRdy_d;
        end
    end

    // ------------------------------------------------------------------
    // Transmitter: left-justified, frame low carries the left channel
    // ------------------------------------------------------------------
    logic [4:0] half_q, half_d;
    logic bclk_q, bclk_d, frm_q, frm_d, dat_q, dat_d;
    logic [BIT_CNT_W-1:0] idx_q, idx_d, len_q, len_d, pos;
    logic pend_q, pend_d, ready_q, ready_d;
    logic [FIFO_W-1:0] pendData_q, pendData_d, act_q, act_d;
    logic [SAMPLE_W-1:0] word;

    always_comb begin
        half_d = half_q + 1'b1;
        bclk_d = bclk_q;
        frm_d = frm_q;
        dat_d = dat_q;
        idx_d = idx_q;
        len_d = len_q;
        act_d = act_q;
        pend_d = pend_q;
        pendData_d = pendData_q;
        pos = '0;
        word = '0;
        if (sampleValid && ready_q) begin
            pend_d = 1'b1;
            pendData_d = {sampleLeft, sampleRight};
        end
        if (!audioOn) begin
            half_d = '0;
            bclk_d = 1'b0;
            frm_d = 1'b0;
            dat_d = 1'b0;
            idx_d = len_q - 1'b1;
        end else if (half_q == 5'(BCLK_HALF_CYC - 1)) begin
            half_d = '0;
            bclk_d = !bclk_q;
            // Frame and data move only on the falling bit-clock edge
            if (bclk_q) begin
                if (idx_q >= len_q - 1'b1) begin
                    idx_d = '0;
                    len_d = ratioBits(sai_ratio_e'(ratioSel));
                    act_d = pend_q ? pendData_q : '0;
                    if (pend_q) begin
                        pend_d = 1'b0;
                    end
                end else begin
                    idx_d = idx_q + 1'b1;
                end
                frm_d = (idx_d >= {1'b0, len_d[BIT_CNT_W-1:1]});
                pos = frm_d ? idx_d - {1'b0, len_d[BIT_CNT_W-1:1]} : idx_d;
                word = frm_d ? act_d[SAMPLE_W-1:0] : act_d[FIFO_W-1:SAMPLE_W];
                dat_d = (pos < BIT_CNT_W'(SAMPLE_W))
                    ? word[4'(SAMPLE_W - 1) - pos[3:0]] : 1'b0;
            end
        end
        ready_d = !pend_d;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            half_q <= '0;
            bclk_q <= 1'b0;
            frm_q <= 1'b0;
            dat_q <= 1'b0;
            idx_q <= 7'h3F;
            len_q <= 7'h40;
            act_q <= '0;
            pend_q <= 1'b0;
            pendData_q <= '0;
            ready_q <= 1'b0;
        end else begin
            half_q <= half_d;
            bclk_q <= bclk_d;
            frm_q <= frm_d;
            dat_q <= dat_d;
            idx_q <= idx_d;
            len_q <= len_d;
            act_q <= act_d;
            pend_q <= pend_d;
            pendData_q <= pendData_d;
            ready_q <= ready_d;
        end
    end

    assign link.bitClock = bclk_q;
    assign link.frameClock = frm_q;
    assign link.serialData = dat_q;
    assign link.resetN = linkRst_q;
    assign link.powerDownN = linkPdn_q;
    assign sampleReady = ready_q;
    assign controlReady = ctrlRdy_q;
endmodule : sai_host
`default_nettype wire

// [tb/sai_link_properties.sv]
// Protocol checker watching the serial audio link between host and device
`timescale 1ns/1ps
`default_nettype none
module sai_link_properties #(
    parameter int unsigned RST_CYC = 40
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic bitClock,
    input wire logic frameClock,
    input wire logic serialData,
    input wire logic resetN,
    input wire logic powerDownN
);
    // ------------------------------------------------------------------
    // Helper counters
    // ------------------------------------------------------------------
    logic bitPrev_q, framePrev_q, bitRise, frameEdge;
    logic [7:0] halfCnt_q, halfCnt_d, lastHalf_q, lastHalf_d;
    logic [15:0] lowCnt_q, lowCnt_d;
    logic [1:0] seen_q, seen_d;

    // The first half after start-up also counts the lead-in rise, so it is skipped
    always_comb begin
        bitRise = bitClock && !bitPrev_q;
        frameEdge = frameClock != framePrev_q;
        halfCnt_d = frameEdge ? 8'h00 : halfCnt_q + {7'h00, bitRise};
        lastHalf_d = frameEdge ? halfCnt_q : lastHalf_q;
        seen_d = (frameEdge && seen_q != 2'h2) ? seen_q + 2'h1 : seen_q;
        lowCnt_d = lowCnt_q;
        if (resetN) begin
            lowCnt_d = 16'h0000;
        end else if (powerDownN && lowCnt_q != 16'hFFFF) begin
            lowCnt_d = lowCnt_q + 16'h0001;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bitPrev_q <= 1'b0;
            framePrev_q <= 1'b0;
            halfCnt_q <= 8'h00;
            lastHalf_q <= 8'h00;
            seen_q <= 2'h0;
            lowCnt_q <= 16'h0000;
        end else begin
            bitPrev_q <= bitClock;
            framePrev_q <= frameClock;
            halfCnt_q <= halfCnt_d;
            lastHalf_q <= lastHalf_d;
            seen_q <= seen_d;
            lowCnt_q <= lowCnt_d;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    frame_on_fall_a: assert property ($changed(frameClock) |-> $fell(bitClock))
        else $error("frame clock moved away from a bit clock fall");
    data_on_fall_a: assert property ($changed(serialData) |-> $fell(bitClock))
        else $error("serial data moved away from a bit clock fall");
    bit_high_len_a: assert property ($rose(bitClock) |->
        bitClock[*8] ##1 bitClock[*8] ##1 !bitClock)
        else $error("bit clock high phase not 16 cycles");
    bit_low_len_a: assert property ($fell(bitClock) |->
        !bitClock[*8] ##1 !bitClock[*8] ##1 bitClock)
        else $error("bit clock low phase not 16 cycles");
    half_bits_a: assert property (frameEdge && seen_q != 2'h0 |->
        halfCnt_q inside {8'h10, 8'h18, 8'h20})
        else $error("frame half has an illegal bit count");
    equal_halves_a: assert property (frameEdge && !frameClock && seen_q == 2'h2 |->
        halfCnt_q == lastHalf_q)
        else $error("left and right slots differ in length");
    reset_hold_a: assert property ($rose(resetN) |-> lowCnt_q >= 16'(RST_CYC))
        else $error("reset released too soon after power-down release");
    pdn_first_a: assert property (resetN |-> powerDownN)
        else $error("reset high while power-down still low");
    reset_idle_a: assert property (!resetN |-> !bitClock && !frameClock)
        else $error("link clocks running while reset held");

    cover property (frameEdge && halfCnt_q == 8'h10);
    cover property (frameEdge && halfCnt_q == 8'h18);
    cover property (frameEdge && halfCnt_q == 8'h20);
endmodule : sai_link_properties
`default_nettype wire

// [tb/testbench.sv]
// Self-checking bench joining the host and device ends over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sai_pkg::*;
    localparam int unsigned RST_CYC = 40;
    localparam int unsigned READY_CYC = 100;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic sampleValid = 1'b0;
    logic [SAMPLE_W-1:0] sampleLeft = '0;
    logic [SAMPLE_W-1:0] sampleRight = '0;
    logic [1:0] ratioSel = 2'h0;
    logic audioReady = 1'b0;
    logic stall = 1'b0;
    logic sampleReady, controlReady, audioValid, mute, carrier288, overrun;
    logic [SAMPLE_W-1:0] audioLeft, audioRight;
    logic [31:0] rng = 32'hA16763D2;
    logic [31:0] expQ[$];
    int errCount = 0;
    int nChecks = 0;
    int cnt;
    int frameCyc;

    sai_link_if link();
    sai_host #(.RST_CYC(RST_CYC), .READY_CYC(READY_CYC)) u_sai_host (.clock(clock),
        .nrst(nrst), .link(link), .sampleValid(sampleValid), .sampleLeft(sampleLeft),
        .sampleRight(sampleRight), .sampleReady(sampleReady), .ratioSel(ratioSel),
        .controlReady(controlReady));
    sai_device u_sai_device (.clock(clock), .nrst(nrst), .link(link),
        .audioValid(audioValid), .audioLeft(audioLeft), .audioRight(audioRight),
        .audioReady(audioReady), .mute(mute), .carrier288(carrier288), .overrun(overrun));
    sai_link_properties #(.RST_CYC(RST_CYC)) u_sai_link_properties (.clock(clock),
        .nrst(nrst), .bitClock(link.bitClock), .frameClock(link.frameClock),
        .serialData(link.serialData), .resetN(link.resetN), .powerDownN(link.powerDownN));

    always #(CLK_PERIOD_NS / 2.0) clock = ~clock;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xorshift

    task automatic check(input string what, input logic [31:0] expv, input logic [31:0] got);
        nChecks++;
        if (got !== expv) begin
            errCount++;
            $display("ERROR %s expected %h seen %h", what, expv, got);
        end
    endtask : check

    task automatic testDone();
        $display("Checks %0d mismatches %0d", nChecks, errCount);
        if (errCount == 0 && nChecks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : testDone

    task automatic timeout(input string what);
        errCount++;
        $display("ERROR %s expected done seen timeout", what);
        testDone();
    endtask : timeout

    function automatic logic pick(input int w);
        case (w)
            0: return mute;
            1: return controlReady;
            2: return link.resetN;
            default: return overrun;
        endcase
    endfunction : pick

    task automatic wait_level(input string what, input int w, input logic lvl, output int n);
        n = 0;
        while (pick(w) !== lvl) begin
            @(posedge clock);
            n++;
            if (n > 20000) timeout(what);
        end
    endtask : wait_level

    // Offer one pair and hold it until the host takes it
    task automatic send_pair(input logic record);
        logic [31:0] r;
        r = rng | 32'h00010001;
        @(posedge clock);
        sampleValid <= 1'b1;
        sampleLeft <= r[31:16];
        sampleRight <= r[15:0];
        cnt = 0;
        @(posedge clock);
        while (sampleReady !== 1'b1) begin
            @(posedge clock);
            cnt++;
            if (cnt > 3000) timeout("sampleAccept");
        end
        if (record) expQ.push_back(r);
        sampleValid <= 1'b0;
    endtask : send_pair

    // ------------------------------------------------------------------
    // Sink side: random stalls, and compare in arrival order
    // ------------------------------------------------------------------
    always @(posedge clock) begin
        rng <= xorshift(rng);
        audioReady <= !stall && (rng[3] || rng[2]);
    end

    // Zero pairs are filler frames sent while no pair is pending
    always @(posedge clock) begin
        if (audioValid === 1'b1 && audioReady === 1'b1 && {audioLeft, audioRight} !== 32'h0) begin
            if (expQ.size() == 0) check("extraPair", 32'h0, {audioLeft, audioRight});
            else check("audioPair", expQ.pop_front(), {audioLeft, audioRight});
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        check("muteAfterReset", 1, mute);
        wait_level("linkReset", 2, 1'b1, cnt);
        wait_level("controlReady", 1, 1'b1, cnt);
        check("readyDelay", 1, cnt + 1 >= READY_CYC && cnt <= READY_CYC + 1);
        $display("Test start-up done");
        for (int s = 0; s < 4; s++) begin
            ratioSel <= 2'(s);
            frameCyc = (s == 1 ? 48 : s == 2 ? 64 : 32) * 2 * BCLK_HALF_CYC;
            if (s > 0) wait_level("muteOnDrift", 0, 1'b1, cnt);
            wait_level("unmute", 0, 1'b0, cnt);
            check("lockTime", 1, cnt >= frameCyc);
            repeat (5) send_pair(1'b1);
            cnt = 0;
            while (expQ.size() != 0) begin
                @(posedge clock);
                cnt++;
                if (cnt > 6000) timeout("drain");
            end
            check("carrier384", 0, carrier288);
            check("noOverrun", 0, overrun);
            $display("Test ratio %0d done", s);
        end
        stall <= 1'b1;
        // The last accepted pair is still in flight, so offer more than FIFO plus output stage
        repeat (22) send_pair(1'b0);
        check("overrunFlag", 1, overrun);
        check("validHeld", 1, audioValid);
        $display("Test overrun done");
        testDone();
    end
endmodule : testbench
`default_nettype wire
